// file: common/pacc_regs.vh
`ifndef PACC_REGS_VH
`define PACC_REGS_VH

// register addresses
`define PACC_A_CTRL 8'h00
`define PACC_A_CMP 8'h01
`define PACC_A_START 8'h02
`define PACC_A_STATUS 8'h03
`define PACC_A_EVCTRL 8'h04
`define PACC_A_CHCTRL 6'h02
`define PACC_A_CHRES 6'h03

// global control fields
`define PACC_CTRL_EN 0
`define PACC_CTRL_SIGNED 1
`define PACC_CTRL_RES8 2
`define PACC_CTRL_PRE_LO 4
`define PACC_CTRL_PRE_HI 6
`define PACC_CTRL_SRC_LO 8
`define PACC_CTRL_SRC_HI 11
`define PACC_CTRL_MASK 16'h0F77

// per-channel control fields
`define PACC_CH_MODE_LO 0
`define PACC_CH_MODE_HI 1
`define PACC_CH_GAIN_LO 2
`define PACC_CH_GAIN_HI 4
`define PACC_CH_INT_LO 5
`define PACC_CH_INT_HI 6
`define PACC_CH_POS_LO 8
`define PACC_CH_POS_HI 11
`define PACC_CH_NEG_LO 12
`define PACC_CH_NEG_HI 13
`define PACC_CH_MASK 16'h3F7F

// input modes
`define PACC_MODE_INTERNAL 2'h0
`define PACC_MODE_SINGLE 2'h1
`define PACC_MODE_DIFF 2'h2
`define PACC_MODE_DIFFGAIN 2'h3

// flag conditions
`define PACC_INT_COMPLETE 2'h0
`define PACC_INT_BELOW 2'h1
`define PACC_INT_ABOVE 2'h2

// gain codes: 1x 2x 4x 8x 16x 32x 64x then half
`define PACC_GAIN_1X 3'h0
`define PACC_GAIN_HALF 3'h7

// internal sources on the positive select
`define PACC_INT_TEMP 4'h0
`define PACC_INT_BANDGAP 4'h1
`define PACC_INT_SUPPLY10 4'h2
`define PACC_INT_DAC 4'h3

// negative input source
`define PACC_NEG_PIN 2'h0
`define PACC_NEG_GND 2'h1
`define PACC_NEG_HALFREF 2'h2

// pipeline latency in converter ticks, sample cycle included
`define PACC_LAT12 3'h7
`define PACC_LAT8 3'h5
`define PACC_PRE_BASE 10'h004

`endif

// file: logic/pacc_chan.v
`timescale 1ns/1ps
`include "pacc_regs.vh"

module pacc_chan (
	input wire clk, // system clock
	input wire rst, // synchronous reset, high
	input wire ctrl_we, // write of this channel's control
	input wire [15:0] wdata, // write data
	input wire flag_clr, // software clears the flag
	input wire done, // this channel's conversion completes
	input wire [11:0] raw, // converter output at completion
	input wire res8, // 8-bit result
	input wire signed_mode, // signed results
	input wire [11:0] cmp, // shared threshold
	output reg [15:0] ctrl, // channel control
	output reg [15:0] result, // channel result
	output reg flag, // sticky channel flag
	output reg event_pulse, // event on flagged completion
	output reg dma_pulse // dma trigger per completion
);
	wire [1:0] int_mode = ctrl[`PACC_CH_INT_HI:`PACC_CH_INT_LO];
	wire above = signed_mode ? ($signed(raw) > $signed(cmp)) : (raw > cmp);
	wire below = signed_mode ? ($signed(raw) < $signed(cmp)) : (raw < cmp);
	// in the below and above modes the threshold decides whether the flag rises; complete mode always sets it
	wire hit = (int_mode == `PACC_INT_COMPLETE) ||
		(int_mode == `PACC_INT_ABOVE && above) ||
		(int_mode == `PACC_INT_BELOW && below);
	reg [15:0] next_result;

	always @* begin
		case ({signed_mode, res8})
			2'b00: next_result = {4'h0, raw};
			2'b01: next_result = {8'h00, raw[11:4]};
			2'b10: next_result = {{4{raw[11]}}, raw};
			default: next_result = {{8{raw[11]}}, raw[11:4]};
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			ctrl <= 16'h0000;
			result <= 16'h0000;
			flag <= 1'b0;
			event_pulse <= 1'b0;
			dma_pulse <= 1'b0;
		end else begin
			if (ctrl_we)
				ctrl <= wdata & `PACC_CH_MASK;
			// only this channel's completion touches its result
			if (done)
				result <= next_result;
			// set wins over a clear in the same cycle
			flag <= (flag & ~flag_clr) | (done & hit);
			event_pulse <= done & hit;
			dma_pulse <= done;
		end
	end
endmodule

// file: logic/pacc_top.v
`timescale 1ns/1ps
`include "pacc_regs.vh"

module pacc_top #(
	parameter NCH = 4, // conversion channels
	parameter PIPE_DEPTH = 7 // longest pipeline latency in ticks
) (
	input wire CLOCK, // 40 MHz system clock
	input wire RESET, // synchronous reset, high
	input wire [7:0] ADDR, // register address
	input wire [15:0] WDATA, // register write data
	input wire WR, // write strobe
	input wire RD, // read strobe
	output reg [15:0] RDATA, // read data, cycle after RD
	input wire [3:0] EVENT_START, // system event start per channel
	input wire [11:0] ADC_DATA, // converter output for completing slot
	output reg ADC_TICK, // converter clock enable pulse
	output reg SAMPLE, // converter samples the selected input
	output reg GAIN_SAMPLE, // gain stage samples and amplifies
	output reg GAIN_EN, // gain stage in the path
	output reg [2:0] GAIN_SEL, // gain code
	output reg POS_INTERNAL, // positive input is an internal source
	output reg [3:0] POS_SEL, // positive pin or internal source
	output reg [1:0] NEG_SRC, // negative source kind
	output reg [2:0] NEG_PIN, // negative pin number
	output wire SIGNED_MODE, // signed conversion mode
	output wire [3:0] SRC_ON, // internal source power enables
	output wire [3:0] CH_EVENT, // channel event pulses
	output wire [3:0] CH_IRQ, // channel interrupt requests
	output wire [3:0] CH_DMA // channel dma triggers
);
	reg [15:0] ctrl;
	reg [11:0] cmp;
	reg [3:0] ev_en;
	reg [3:0] pending;
	reg [9:0] pre_cnt;
	reg gain_busy;
	reg [1:0] gain_ch;
	reg pipe_vld [0:PIPE_DEPTH-1];
	reg [1:0] pipe_ch [0:PIPE_DEPTH-1];
	reg [3:0] next_pending;
	reg [1:0] pick;
	reg [15:0] pick_ctrl;
	reg [15:0] rd_mux;
	integer i;

	wire [16*NCH-1:0] ch_ctrl;
	wire [16*NCH-1:0] ch_res;
	wire [NCH-1:0] ch_flag;
	wire enabled = ctrl[`PACC_CTRL_EN];
	wire res8 = ctrl[`PACC_CTRL_RES8];
	wire [2:0] pre = ctrl[`PACC_CTRL_PRE_HI:`PACC_CTRL_PRE_LO];
	wire [9:0] pre_limit = (`PACC_PRE_BASE << pre) - 10'h001;
	wire tick = enabled && (pre_cnt == pre_limit);
	wire wr_ctrl = WR && ADDR == `PACC_A_CTRL;
	wire wr_start = WR && ADDR == `PACC_A_START;
	wire wr_status = WR && ADDR == `PACC_A_STATUS;
	wire [2:0] ins_idx = res8 ? (`PACC_LAT8 - 3'h1) : (`PACC_LAT12 - 3'h1);
	wire done_now = tick && pipe_vld[0];
	wire can_take = tick && !gain_busy && pending != 4'h0;

	assign SIGNED_MODE = ctrl[`PACC_CTRL_SIGNED];
	assign SRC_ON = ctrl[`PACC_CTRL_SRC_HI:`PACC_CTRL_SRC_LO];
	assign CH_IRQ = ch_flag;

	// lowest pending channel wins; the scan of all four is combinational and settles in the same cycle
	always @* begin
		pick = 2'h0;
		for (i = NCH - 1; i >= 0; i = i - 1)
			if (pending[i])
				pick = i[1:0];
		pick_ctrl = ch_ctrl[16*pick +: 16];
	end

	// starts from software and from events, several at once
	always @* begin
		next_pending = pending;
		if (can_take)
			next_pending[pick] = 1'b0;
		if (wr_start)
			next_pending = next_pending | WDATA[3:0];
		next_pending = next_pending | (EVENT_START & ev_en);
		if (!enabled)
			next_pending = 4'h0;
	end

	always @(posedge CLOCK) begin
		if (RESET) begin
			ctrl <= 16'h0000;
			cmp <= 12'h000;
			ev_en <= 4'h0;
			pending <= 4'h0;
		end else begin
			if (wr_ctrl)
				ctrl <= WDATA & `PACC_CTRL_MASK;
			if (WR && ADDR == `PACC_A_CMP)
				cmp <= WDATA[11:0];
			if (WR && ADDR == `PACC_A_EVCTRL)
				ev_en <= WDATA[3:0];
			pending <= next_pending;
		end
	end

	// converter clock prescaler
	always @(posedge CLOCK) begin
		if (RESET) begin
			pre_cnt <= 10'h000;
			ADC_TICK <= 1'b0;
		end else begin
			ADC_TICK <= tick;
			if (!enabled || tick || wr_ctrl)
				pre_cnt <= 10'h000;
			else
				pre_cnt <= pre_cnt + 10'h001;
		end
	end

	// dispatch into the shared pipeline, one sample per tick
	always @(posedge CLOCK) begin
		if (RESET) begin
			gain_busy <= 1'b0;
			gain_ch <= 2'h0;
			SAMPLE <= 1'b0;
			GAIN_SAMPLE <= 1'b0;
			GAIN_EN <= 1'b0;
			GAIN_SEL <= `PACC_GAIN_1X;
			POS_INTERNAL <= 1'b0;
			POS_SEL <= 4'h0;
			NEG_SRC <= `PACC_NEG_GND;
			NEG_PIN <= 3'h0;
		end else begin
			SAMPLE <= 1'b0;
			GAIN_SAMPLE <= 1'b0;
			if (!enabled) begin
				gain_busy <= 1'b0;
			end else if (tick && gain_busy) begin
				// amplified value enters the converter one tick later
				SAMPLE <= 1'b1;
				gain_busy <= 1'b0;
			end else if (can_take) begin
				POS_SEL <= pick_ctrl[`PACC_CH_POS_HI:`PACC_CH_POS_LO];
				GAIN_SEL <= pick_ctrl[`PACC_CH_GAIN_HI:`PACC_CH_GAIN_LO];
				NEG_PIN <= 3'h0;
				POS_INTERNAL <= 1'b0;
				GAIN_EN <= 1'b0;
				case (pick_ctrl[`PACC_CH_MODE_HI:`PACC_CH_MODE_LO])
					`PACC_MODE_DIFF: begin
						NEG_SRC <= `PACC_NEG_PIN;
						NEG_PIN <= {1'b0, pick_ctrl[`PACC_CH_NEG_HI:`PACC_CH_NEG_LO]};
						SAMPLE <= 1'b1;
					end
					`PACC_MODE_DIFFGAIN: begin
						NEG_SRC <= `PACC_NEG_PIN;
						NEG_PIN <= {1'b1, pick_ctrl[`PACC_CH_NEG_HI:`PACC_CH_NEG_LO]};
						GAIN_EN <= 1'b1;
						GAIN_SAMPLE <= 1'b1;
						gain_busy <= 1'b1;
						gain_ch <= pick;
					end
					`PACC_MODE_SINGLE: begin
						NEG_SRC <= SIGNED_MODE ? `PACC_NEG_GND : `PACC_NEG_HALFREF;
						SAMPLE <= 1'b1;
					end
					default: begin
						POS_INTERNAL <= 1'b1;
						NEG_SRC <= SIGNED_MODE ? `PACC_NEG_GND : `PACC_NEG_HALFREF;
						SAMPLE <= 1'b1;
					end
				endcase
			end
		end
	end

	// latency tracker: a slot enters at index latency minus one and retires at 0
	always @(posedge CLOCK) begin
		if (RESET) begin
			for (i = 0; i < PIPE_DEPTH; i = i + 1) begin
				pipe_vld[i] <= 1'b0;
				pipe_ch[i] <= 2'h0;
			end
		end else if (!enabled) begin
			for (i = 0; i < PIPE_DEPTH; i = i + 1)
				pipe_vld[i] <= 1'b0;
		end else if (tick) begin
			for (i = 0; i < PIPE_DEPTH - 1; i = i + 1) begin
				pipe_vld[i] <= pipe_vld[i+1];
				pipe_ch[i] <= pipe_ch[i+1];
			end
			pipe_vld[PIPE_DEPTH-1] <= 1'b0;
			if (gain_busy) begin
				pipe_vld[ins_idx] <= 1'b1;
				pipe_ch[ins_idx] <= gain_ch;
			end else if (can_take &&
				pick_ctrl[`PACC_CH_MODE_HI:`PACC_CH_MODE_LO] != `PACC_MODE_DIFFGAIN) begin
				pipe_vld[ins_idx] <= 1'b1;
				pipe_ch[ins_idx] <= pick;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : chan
			// a genvar cannot be part-selected, so the channel number gets a sized copy
			localparam [1:0] CH_NUM = g;
			pacc_chan u_chan (
				.clk(CLOCK),
				.rst(RESET),
				.ctrl_we(WR && ADDR == {`PACC_A_CHCTRL, CH_NUM}),
				.wdata(WDATA),
				.flag_clr(wr_status && WDATA[g]),
				.done(done_now && pipe_ch[0] == CH_NUM),
				.raw(ADC_DATA),
				.res8(res8),
				.signed_mode(SIGNED_MODE),
				.cmp(cmp),
				.ctrl(ch_ctrl[16*g +: 16]),
				.result(ch_res[16*g +: 16]),
				.flag(ch_flag[g]),
				.event_pulse(CH_EVENT[g]),
				.dma_pulse(CH_DMA[g])
			);
		end
	endgenerate

	always @* begin
		rd_mux = 16'h0000;
		case (ADDR)
			`PACC_A_CTRL: rd_mux = ctrl;
			`PACC_A_CMP: rd_mux = {4'h0, cmp};
			`PACC_A_START: rd_mux = {12'h000, pending};
			`PACC_A_STATUS: rd_mux = {12'h000, ch_flag};
			`PACC_A_EVCTRL: rd_mux = {12'h000, ev_en};
			default: begin
				if (ADDR[7:2] == `PACC_A_CHCTRL)
					rd_mux = ch_ctrl[16*ADDR[1:0] +: 16];
				else if (ADDR[7:2] == `PACC_A_CHRES)
					rd_mux = ch_res[16*ADDR[1:0] +: 16];
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge CLOCK) begin
		if (RESET)
			RDATA <= 16'h0000;
		else if (RD)
			RDATA <= rd_mux;
		else
			RDATA <= 16'h0000;
	end
endmodule

// file: tb/pacc_analog.sv
`timescale 1ns/1ps
// analog side: a steady input level, so the code held at retirement is that level
module pacc_analog (
	input wire CLOCK, // clock
	input wire SAMPLE, // converter samples
	input wire POS_INTERNAL, // internal source chosen
	input wire [3:0] POS_SEL, // positive select
	input wire [3:0] SRC_ON, // source enables
	input wire [11:0] level, // input level as a code
	output wire [11:0] ADC_DATA, // converter output
	output reg fault // unpowered source sampled
);
	initial fault = 1'b0;
	always @(posedge CLOCK) begin
		if (SAMPLE && POS_INTERNAL && !SRC_ON[POS_SEL[1:0]]) begin
			fault <= 1'b1;
		end
	end
	assign ADC_DATA = level;
endmodule

// file: tb/pacc_chk_assertions.sv
`timescale 1ns/1ps
`include "pacc_regs.vh"
module pacc_chk (
	input wire CLOCK, // clock
	input wire RESET, // reset, high
	input wire RD, // read strobe
	input wire [15:0] RDATA, // read data
	input wire ADC_TICK, // converter tick
	input wire SAMPLE, // converter sample
	input wire GAIN_SAMPLE, // gain stage sample
	input wire GAIN_EN, // gain in path
	input wire POS_INTERNAL, // internal positive
	input wire [3:0] POS_SEL, // positive select
	input wire [1:0] NEG_SRC, // negative kind
	input wire [2:0] NEG_PIN, // negative pin
	input wire SIGNED_MODE, // signed mode
	input wire [3:0] CH_EVENT, // channel events
	input wire [3:0] CH_DMA // channel dma
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	sequence s_pin;
		SAMPLE && NEG_SRC == `PACC_NEG_PIN;
	endsequence
	sequence s_quiet;
		!SAMPLE [*3];
	endsequence
	property p_rd; !$past(RD) |-> RDATA == 16'h0000; endproperty
	property p_tick; SAMPLE |-> ADC_TICK ##1 s_quiet; endproperty
	property p_gain; GAIN_SAMPLE |-> GAIN_EN ##1 s_quiet ##[1:600] (SAMPLE && GAIN_EN); endproperty
	property p_negd; s_pin and !GAIN_EN |-> NEG_PIN <= 3'h3; endproperty
	property p_negg; s_pin and GAIN_EN |-> NEG_PIN >= 3'h4; endproperty
	property p_gnd; SAMPLE && SIGNED_MODE && NEG_SRC != `PACC_NEG_PIN |->
		NEG_SRC == `PACC_NEG_GND; endproperty
	property p_half; SAMPLE && !SIGNED_MODE |-> NEG_SRC == `PACC_NEG_HALFREF; endproperty
	property p_int; SAMPLE && POS_INTERNAL |-> !GAIN_EN && POS_SEL <= 4'h3; endproperty
	property p_ev; |CH_EVENT |-> (CH_EVENT & ~CH_DMA) == 4'h0; endproperty
	property p_dma; |CH_DMA |-> ADC_TICK ##1 CH_DMA == 4'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data outside answer cycle");
	a_tick: assert property (p_tick) else $error("sample off tick");
	a_gain: assert property (p_gain) else $error("gain sample order");
	a_negd: assert property (p_negd) else $error("diff negative pin");
	a_negg: assert property (p_negg) else $error("gain negative pin");
	a_gnd: assert property (p_gnd) else $error("signed negative not ground");
	a_half: assert property (p_half) else $error("unsigned negative");
	a_int: assert property (p_int) else $error("internal source select");
	a_ev: assert property (p_ev) else $error("event without completion");
	a_dma: assert property (p_dma) else $error("dma pulse shape");
endmodule
bind pacc_top pacc_chk chk_u (.*);

// file: tb/pacc_top_test.sv
`timescale 1ns/1ps
module pacc_top_test;
	reg clk, rst, wr, rd;
	reg [7:0] a;
	reg [15:0] wd, q;
	reg [3:0] ev, msk;
	reg [11:0] lvl;
	reg [15:0] ex [0:3];
	wire [15:0] rdata;
	wire [11:0] adc;
	wire [3:0] pos, src, irq, evo, dma;
	wire [1:0] neg;
	wire [2:0] gs, np;
	wire samp, pint, fault;
	integer bad_count, n_checks, k, j;
	pacc_top dut_u (.CLOCK(clk), .RESET(rst), .ADDR(a), .WDATA(wd), .WR(wr), .RD(rd),
		.RDATA(rdata), .EVENT_START(ev), .ADC_DATA(adc), .ADC_TICK(), .SAMPLE(samp),
		.GAIN_SAMPLE(), .GAIN_EN(), .GAIN_SEL(gs), .POS_INTERNAL(pint), .POS_SEL(pos),
		.NEG_SRC(neg), .NEG_PIN(np), .SIGNED_MODE(), .SRC_ON(src), .CH_EVENT(evo),
		.CH_IRQ(irq), .CH_DMA(dma));
	pacc_analog an_u (.CLOCK(clk), .SAMPLE(samp), .POS_INTERNAL(pint), .POS_SEL(pos),
		.SRC_ON(src), .level(lvl), .ADC_DATA(adc), .fault(fault));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task results;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// a gap cycle after each strobe keeps one assignment per signal per step
	task bus(input w, input [7:0] ad, input [15:0] d);
		begin
			a <= ad;
			wd <= d;
			wr <= w;
			rd <= !w;
			@(posedge clk);
			wr <= 1'b0;
			rd <= 1'b0;
			#1 q = rdata;
			@(posedge clk);
		end
	endtask
	function [15:0] xr(input [11:0] r, input s, input e8);
		xr = e8 ? (s ? {{8{r[11]}}, r[11:4]} : {8'h00, r[11:4]})
			: (s ? {{4{r[11]}}, r} : {4'h0, r});
	endfunction
	task conv(input integer n);
		integer i, lat;
		reg [11:0] cv;
		reg [3:0] ps;
		reg [2:0] gn;
		reg [1:0] ng, md, cf;
		reg sg, r8, lt, hit;
		begin
			md = $urandom;
			cf = $urandom % 3;
			gn = $urandom;
			ng = $urandom;
			ps = (md == 2'h0) ? $urandom % 4 : $urandom;
			sg = md[1] | ($urandom & 1);
			r8 = $urandom & 1;
			lvl <= $urandom;
			cv = $urandom;
			@(posedge clk);
			if (cv == lvl) cv = ~lvl;
			lt = sg ? ($signed(lvl) < $signed(cv)) : (lvl < cv);
			hit = (cf == 2'h0) | (cf == 2'h1 ? lt : !lt);
			lat = (r8 ? 5 : 7) + (md == 2'h3);
			bus(1, 8'h00, {4'h0, 4'hF, 5'h00, r8, sg, 1'b1});
			bus(1, 8'h01, {4'h0, cv});
			bus(1, 8'h08 + n, {2'h0, ng, ps, 1'b0, cf, gn, md});
			bus(1, 8'h02, 16'h0001 << n);
			#1;
			for (i = 1; i < 99 && dma[n] !== 1'b1; i = i + 1) begin
				@(posedge clk);
				#1;
			end
			chk(evo[n], hit);
			chk(gs, gn);
			chk(np, md[1] ? {md[0], ng} : 3'h0);
			chk(i >= 4 * lat + 1 && i <= 4 * lat + 5, 1);
			if (i >= 99) results;
			@(posedge clk);
			chk(irq[n], hit);
			ex[n] = xr(lvl, sg, r8);
			for (j = 0; j < 4; j = j + 1) begin
				bus(0, 8'h0C + j, 16'h0000);
				chk(q, ex[j]);
			end
			bus(1, 8'h03, 16'h000F);
			chk(irq, 4'h0);
			$display("conversion done on channel %0d", n);
		end
	endtask
	initial begin
		bad_count = 0;
		n_checks = 0;
		q = $urandom(68382);
		{wr, rd, a, wd, ev, lvl} = 0;
		for (k = 0; k < 4; k = k + 1) ex[k] = 16'h0000;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(neg, 2'h1);
		bus(0, 8'h40, 16'h0000);
		chk(q, 16'h0000);
		bus(1, 8'h0C, 16'hFFFF);
		bus(0, 8'h0C, 16'h0000);
		chk(q, 16'h0000);
		bus(1, 8'h09, 16'hFFFF);
		bus(0, 8'h09, 16'h0000);
		chk(q, 16'h3F7F);
		$display("register test done");
		for (k = 0; k < 24; k = k + 1) conv(k % 4);
		bus(1, 8'h00, 16'h0F03);
		ev <= 4'hF;
		@(posedge clk);
		ev <= 4'h0;
		bus(0, 8'h02, 16'h0000);
		chk(q, 16'h0000);
		bus(1, 8'h04, 16'h000F);
		ev <= 4'hF;
		@(posedge clk);
		ev <= 4'h0;
		msk = 4'h0;
		for (k = 0; k < 200 && msk != 4'hF; k = k + 1) begin
			#1 msk = msk | dma;
			@(posedge clk);
		end
		chk(msk, 4'hF);
		for (j = 0; j < 4; j = j + 1) begin
			bus(0, 8'h0C + j, 16'h0000);
			chk(q, xr(lvl, 1'b1, 1'b0));
		end
		chk(fault, 1'b0);
		$display("event test done");
		results;
	end
endmodule
